// file: rtl/aclre_consts.svh
// Offsets, field positions, reset values and timing counts of the ACL evaluator.
// Assumes inclusion by bare name from the design module.
`ifndef ACLRE_CONSTS_SVH
`define ACLRE_CONSTS_SVH

// Field offsets inside one 16-word table entry.
`define ACLRE_FLD_CTRL   4'h0
`define ACLRE_FLD_MACLO  4'h1
`define ACLRE_FLD_MACHI  4'h2
`define ACLRE_FLD_PARA   4'h3
`define ACLRE_FLD_PARB   4'h4
`define ACLRE_FLD_ACT    4'h5
`define ACLRE_FLD_PROC   4'h6
`define ACLRE_FLD_CNT    4'h7

// Layer select and option select codes.
`define ACLRE_LAYER_OFF  2'h0
`define ACLRE_LAYER_L2   2'h1
`define ACLRE_LAYER_L3   2'h2
`define ACLRE_LAYER_L4   2'h3
`define ACLRE_L2_COUNT   2'h0
`define ACLRE_L2_TYPE    2'h1
`define ACLRE_L2_MAC     2'h2
`define ACLRE_L3_MASKED  2'h1
`define ACLRE_L3_BOTH    2'h2
`define ACLRE_L4_PROTO   2'h0
`define ACLRE_L4_TCP     2'h1
`define ACLRE_L4_UDP     2'h2

// Reset value of every table word.
`define ACLRE_RST_WORD   32'h0000_0000

// Timing.
`define ACLRE_CLK_PERIOD_NS 10
`define ACLRE_US_NS         1000
`define ACLRE_US_CYCLES     (`ACLRE_US_NS / `ACLRE_CLK_PERIOD_NS)
`define ACLRE_MS_US         1000

`endif

// file: rtl/aclre_pkg.sv
// Types shared by the ACL evaluator and its bench.
// Stands alone; it does not include the constants header.
package aclre_pkg;

  typedef struct packed {
    logic [1:0] match_layer_select;
    logic [1:0] match_option_select;
    logic       address_side;
    logic       equality_polarity;
  } aclre_ctrl_t;

  typedef struct packed {
    logic       count_algorithm_select;
    logic       count_time_unit;
    logic [1:0] priority_override_mode;
    logic [2:0] priority_value;
    logic       remark_enable;
    logic [2:0] remarked_priority;
    logic [1:0] forward_map_mode;
  } aclre_action_t;

  typedef struct packed {
    logic [3:0]  action_pointer;
    logic [15:0] rule_select_mask;
  } aclre_proc_t;

  typedef struct packed {
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ether_type;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [7:0]  ip_proto;
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
  } aclre_frame_t;

  typedef struct packed {
    logic          hit;
    logic [3:0]    index;
    aclre_action_t action;
  } aclre_result_t;

endpackage : aclre_pkg

// file: rtl/acl_rule_evaluator.sv
// Per-port ACL evaluator: sixteen matching rules, actions and processing entries.
// Assumes frame headers come from parser logic on I_CLK, one strobe per frame.
//
// Functional notes
// - Processing entry holds 4-bit action pointer, taken when all selected rules true.
// - Sixteen-bit rule select mask, one bit per matching rule.
// - Selected rule results are ANDed to form the entry match.
// - One action per frame; the lowest action pointer among matches wins.
// - Entries sharing an action pointer OR their rule sets.
// - Layer select 00 disables a rule regardless of option.
// - Layer 2 options: 01 EtherType, 10 MAC, 11 both.
// - Layer 3: 01 masked address, 10 both addresses unmasked, others reserved.
// - Layer 4: 00 protocol, 01 TCP port, 10 UDP port, 11 TCP sequence.
// - Address side bit picks destination when 0, source when 1.
// - Equality polarity 0 makes mismatch true, 1 makes match true.
// - Layer 2 option 00 is count mode on MAC and EtherType.
// - Count value is the 11 action bits from priority through map mode.
// - Time unit bit selects microsecond when 0, millisecond when 1.
// - Algorithm 0 reloads a down-counter; expiry raises an event.
// - Algorithm 1 counts matching frames; terminal count raises event and clears.
// - A count rule uses the action entry at its own index as storage.
// - All sixteen rules are evaluated before the action is resolved.
`timescale 1ns/1ps
`include "aclre_consts.svh"

module acl_rule_evaluator #(
  parameter int N_ENTRY = 16
) (
  // Clock and reset.
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_N,
  // Register port.
  input  wire logic [7:0]             I_ADDR,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic      [31:0]            O_RDATA,
  // Frame header in, action result out.
  input  wire logic                   I_FRAME_VALID,
  input  wire aclre_pkg::aclre_frame_t I_FRAME,
  output logic                        O_RES_VALID,
  output aclre_pkg::aclre_result_t    O_RESULT,
  // Count events, one pulse per rule.
  output logic      [N_ENTRY-1:0]     O_CNT_EVENT
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic logic [47:0] pick_mac(input logic side,
                                           input aclre_pkg::aclre_frame_t f);
    return side ? f.src_mac : f.dst_mac;
  endfunction : pick_mac

  function automatic logic rule_eval(input aclre_pkg::aclre_ctrl_t c,
                                     input logic [31:0] mlo,
                                     input logic [31:0] mhi,
                                     input logic [31:0] pa,
                                     input logic [31:0] pb,
                                     input aclre_pkg::aclre_frame_t f);
    logic        ok;
    logic        eqv;
    logic        mac_eq;
    logic        type_eq;
    logic [31:0] ip;
    logic [15:0] port;
    ok      = 1'b1;
    eqv     = 1'b0;
    mac_eq  = pick_mac(c.address_side, f) == {mhi[15:0], mlo};
    type_eq = f.ether_type == mhi[31:16];
    ip      = c.address_side ? f.src_ip : f.dst_ip;
    port    = c.address_side ? f.src_port : f.dst_port;
    case (c.match_layer_select)
      `ACLRE_LAYER_L2: begin
        case (c.match_option_select)
          `ACLRE_L2_COUNT: ok = 1'b0;
          `ACLRE_L2_TYPE:  eqv = type_eq;
          `ACLRE_L2_MAC:   eqv = mac_eq;
          default:         eqv = mac_eq & type_eq;
        endcase
      end
      `ACLRE_LAYER_L3: begin
        case (c.match_option_select)
          `ACLRE_L3_MASKED: eqv = ((ip ^ pa) & ~pb) == 32'h0000_0000;
          `ACLRE_L3_BOTH:   eqv = (f.src_ip == pa) && (f.dst_ip == pb);
          default:          ok = 1'b0;
        endcase
      end
      `ACLRE_LAYER_L4: begin
        case (c.match_option_select)
          `ACLRE_L4_PROTO: eqv = f.ip_proto == pa[7:0];
          `ACLRE_L4_TCP: begin
            ok  = f.is_tcp;
            eqv = port == pa[15:0];
          end
          `ACLRE_L4_UDP: begin
            ok  = f.is_udp;
            eqv = port == pa[15:0];
          end
          default: begin
            ok  = f.is_tcp;
            eqv = f.tcp_seq == pa;
          end
        endcase
      end
      default: ok = 1'b0;
    endcase
    return ok & (c.equality_polarity ? eqv : ~eqv);
  endfunction : rule_eval

  ////////////////////////////////////////////////////////////////////////////
  // Table storage and register port.

  aclre_pkg::aclre_ctrl_t   ctrl_q  [N_ENTRY];
  logic [31:0]              maclo_q [N_ENTRY];
  logic [31:0]              machi_q [N_ENTRY];
  logic [31:0]              para_q  [N_ENTRY];
  logic [31:0]              parb_q  [N_ENTRY];
  aclre_pkg::aclre_action_t act_q   [N_ENTRY];
  aclre_pkg::aclre_proc_t   proc_q  [N_ENTRY];
  logic [10:0]              cnt_q   [N_ENTRY];
  logic [31:0]              rdata_d;

  wire logic [3:0] wr_idx = I_ADDR[7:4];
  wire logic [3:0] wr_fld = I_ADDR[3:0];

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < N_ENTRY; i++) begin
        ctrl_q[i]  <= '0;
        maclo_q[i] <= `ACLRE_RST_WORD;
        machi_q[i] <= `ACLRE_RST_WORD;
        para_q[i]  <= `ACLRE_RST_WORD;
        parb_q[i]  <= `ACLRE_RST_WORD;
        act_q[i]   <= '0;
        proc_q[i]  <= '0;
      end
    end else if (I_WR) begin
      case (wr_fld)
        `ACLRE_FLD_CTRL:  ctrl_q[wr_idx]  <= I_WDATA[5:0];
        `ACLRE_FLD_MACLO: maclo_q[wr_idx] <= I_WDATA;
        `ACLRE_FLD_MACHI: machi_q[wr_idx] <= I_WDATA;
        `ACLRE_FLD_PARA:  para_q[wr_idx]  <= I_WDATA;
        `ACLRE_FLD_PARB:  parb_q[wr_idx]  <= I_WDATA;
        `ACLRE_FLD_ACT:   act_q[wr_idx]   <= I_WDATA[12:0];
        `ACLRE_FLD_PROC:  proc_q[wr_idx]  <= I_WDATA[19:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (wr_fld)
      `ACLRE_FLD_CTRL:  rdata_d = {26'h000_0000, ctrl_q[wr_idx]};
      `ACLRE_FLD_MACLO: rdata_d = maclo_q[wr_idx];
      `ACLRE_FLD_MACHI: rdata_d = machi_q[wr_idx];
      `ACLRE_FLD_PARA:  rdata_d = para_q[wr_idx];
      `ACLRE_FLD_PARB:  rdata_d = parb_q[wr_idx];
      `ACLRE_FLD_ACT:   rdata_d = {19'h0_0000, act_q[wr_idx]};
      `ACLRE_FLD_PROC:  rdata_d = {12'h000, proc_q[wr_idx]};
      `ACLRE_FLD_CNT:   rdata_d = {21'h00_0000, cnt_q[wr_idx]};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= I_RD ? rdata_d : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: evaluate every matching rule for the frame.

  logic [N_ENTRY-1:0] match_d;
  logic [N_ENTRY-1:0] cnt_hit_d;
  logic [N_ENTRY-1:0] match_q;
  logic [N_ENTRY-1:0] cnt_hit_q;
  logic               s1_valid_q;

  for (genvar r = 0; r < N_ENTRY; r++) begin : g_eval
    wire logic cmode = ctrl_q[r].match_layer_select == `ACLRE_LAYER_L2 &&
                       ctrl_q[r].match_option_select == `ACLRE_L2_COUNT;
    wire logic both  = pick_mac(ctrl_q[r].address_side, I_FRAME) ==
                       {machi_q[r][15:0], maclo_q[r]} &&
                       I_FRAME.ether_type == machi_q[r][31:16];
    assign match_d[r]   = rule_eval(ctrl_q[r], maclo_q[r], machi_q[r],
                                    para_q[r], parb_q[r], I_FRAME);
    assign cnt_hit_d[r] = cmode & (ctrl_q[r].equality_polarity ? both : ~both);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      match_q    <= '0;
      cnt_hit_q  <= '0;
      s1_valid_q <= 1'b0;
    end else begin
      match_q    <= I_FRAME_VALID ? match_d : '0;
      cnt_hit_q  <= I_FRAME_VALID ? cnt_hit_d : '0;
      s1_valid_q <= I_FRAME_VALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: combine rule sets and pick one action.

  logic [N_ENTRY-1:0] entry_ok;
  logic [N_ENTRY-1:0] act_hit;
  logic [3:0]         pick_idx;

  for (genvar e = 0; e < N_ENTRY; e++) begin : g_entry
    wire logic [15:0] msk = proc_q[e].rule_select_mask;
    assign entry_ok[e] = (msk != 16'h0000) && ((match_q & msk) == msk);
  end

  always_comb begin
    act_hit = '0;
    for (int e = 0; e < N_ENTRY; e++) begin
      if (entry_ok[e]) begin
        act_hit[proc_q[e].action_pointer] = 1'b1;
      end
    end
  end

  always_comb begin
    pick_idx = 4'h0;
    for (int a = N_ENTRY - 1; a >= 0; a--) begin
      if (act_hit[a]) begin
        pick_idx = 4'(a);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RES_VALID <= 1'b0;
      O_RESULT    <= '0;
    end else begin
      O_RES_VALID     <= s1_valid_q;
      O_RESULT.hit    <= s1_valid_q && (act_hit != '0);
      O_RESULT.index  <= pick_idx;
      O_RESULT.action <= act_q[pick_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count ticks. The millisecond tick rides on the microsecond one.

  logic [6:0] us_cnt_q;
  logic [9:0] ms_cnt_q;
  wire logic  us_tick = us_cnt_q == 7'(`ACLRE_US_CYCLES - 1);
  wire logic  ms_tick = us_tick && ms_cnt_q == 10'(`ACLRE_MS_US - 1);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      us_cnt_q <= 7'h00;
      ms_cnt_q <= 10'h000;
    end else begin
      us_cnt_q <= us_tick ? 7'h00 : us_cnt_q + 7'h01;
      if (us_tick) begin
        ms_cnt_q <= ms_tick ? 10'h000 : ms_cnt_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count mode counters, one per rule, using the same-index action entry.

  logic [N_ENTRY-1:0] armed_q;

  for (genvar r = 0; r < N_ENTRY; r++) begin : g_cnt
    wire logic [10:0] cvalue = act_q[r][10:0];
    wire logic        utick  = act_q[r].count_time_unit ? ms_tick : us_tick;
    wire logic        clr    = I_WR && wr_idx == 4'(r) &&
                               (wr_fld == `ACLRE_FLD_CTRL || wr_fld == `ACLRE_FLD_ACT);
    wire logic        wdog   = !act_q[r].count_algorithm_select;
    wire logic        expire = wdog && armed_q[r] && utick && cnt_q[r] <= 11'h001 &&
                               !cnt_hit_q[r];
    wire logic        term   = !wdog && cnt_hit_q[r] && cnt_q[r] + 11'h001 == cvalue;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        cnt_q[r]       <= 11'h000;
        armed_q[r]     <= 1'b0;
        O_CNT_EVENT[r] <= 1'b0;
      end else begin
        O_CNT_EVENT[r] <= !clr && (expire || term);
        if (clr) begin
          cnt_q[r]   <= 11'h000;
          armed_q[r] <= 1'b0;
        end else if (wdog && cnt_hit_q[r]) begin
          cnt_q[r]   <= cvalue;
          armed_q[r] <= 1'b1;
        end else if (expire) begin
          cnt_q[r]   <= 11'h000;
          armed_q[r] <= 1'b0;
        end else if (wdog && armed_q[r] && utick) begin
          cnt_q[r] <= cnt_q[r] - 11'h001;
        end else if (term) begin
          cnt_q[r] <= 11'h000;
        end else if (!wdog && cnt_hit_q[r]) begin
          cnt_q[r] <= cnt_q[r] + 11'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks, the per-entry ones on entry 0; the other entries share the same logic.

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  wire logic r0_wdog = !act_q[0].count_algorithm_select;

  res_latency_a: assert property (I_FRAME_VALID |-> ##2 O_RES_VALID)
    else $error("result not two cycles after frame");
  rule_off_a: assert property (
    I_FRAME_VALID && ctrl_q[0].match_layer_select == `ACLRE_LAYER_OFF |=> !match_q[0])
    else $error("disabled rule matched");
  count_silent_a: assert property (I_FRAME_VALID && g_eval[0].cmode |=> !match_q[0])
    else $error("count rule fed a processing entry");
  top_action_a: assert property (s1_valid_q && act_hit[0] |=> O_RESULT.hit && O_RESULT.index == 4'h0)
    else $error("action zero not chosen");
  entry_and_a: assert property (
    s1_valid_q && proc_q[0].rule_select_mask != 16'h0000 &&
    (match_q & proc_q[0].rule_select_mask) == proc_q[0].rule_select_mask && !I_WR
    |=> O_RESULT.hit && O_RESULT.index <= $past(proc_q[0].action_pointer))
    else $error("full rule set did not yield action");
  wdog_reload_a: assert property (cnt_hit_q[0] && r0_wdog && !I_WR |=> cnt_q[0] == $past(act_q[0][10:0]))
    else $error("watchdog not reloaded");
  wdog_expire_a: assert property (O_CNT_EVENT[0] && $past(r0_wdog) |-> $past(armed_q[0]) && $past(cnt_q[0]) <= 11'h001)
    else $error("watchdog event without expiry");
  event_term_a: assert property (
    !r0_wdog && cnt_hit_q[0] && cnt_q[0] + 11'h001 == act_q[0][10:0] && !I_WR
    |=> O_CNT_EVENT[0] && cnt_q[0] == 11'h000)
    else $error("terminal count missed");
  us_tick_a: assert property (us_tick |=> !us_tick [*8])
    else $error("microsecond tick too frequent");

  hit_c:    cover property (O_RES_VALID && O_RESULT.hit);
  or_c:     cover property (s1_valid_q && entry_ok[0] && entry_ok[1]);
  expire_c: cover property (O_CNT_EVENT[0] && $past(r0_wdog));
  term_c:   cover property (O_CNT_EVENT[0] && !$past(r0_wdog));

endmodule : acl_rule_evaluator

// file: verif/aclre_frame_src.sv
// Behavioural ingress parser model that presents one frame header per bench request.
// Assumes requests come on the evaluator clock, one cycle long each.
`timescale 1ns/1ps

module aclre_frame_src (
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Request from the bench.
  input  wire logic                    i_go,
  input  wire aclre_pkg::aclre_frame_t i_frame,
  // Header toward the evaluator.
  output logic                         o_valid,
  output aclre_pkg::aclre_frame_t      o_frame
);
  // Between strobes the fields toggle, so a stale header can never pass for a fresh one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_frame <= '0;
    end else begin
      o_valid <= i_go;
      o_frame <= i_go ? i_frame : ~o_frame;
    end
  end
endmodule : aclre_frame_src

// file: verif/acl_rule_evaluator_tb_top.sv
// Self-checking bench for the ACL evaluator: table access, options, priority and counts.
// Assumes the design package and the frame source model are compiled before it.
`timescale 1ns/1ps

module acl_rule_evaluator_tb_top;
  logic                     clk;
  logic                     rst_n;
  logic [7:0]               addr;
  logic [31:0]              wdata;
  logic                     wr_en;
  logic                     rd_en;
  logic [31:0]              rdata;
  logic                     go;
  aclre_pkg::aclre_frame_t  req;
  logic                     fvalid;
  aclre_pkg::aclre_frame_t  frame;
  logic                     res_valid;
  aclre_pkg::aclre_result_t result;
  logic [15:0]              evt;
  logic [12:0]              act_mem [16];
  logic [6:0]               cases [13];
  logic [7:0]               prio [6];
  aclre_pkg::aclre_frame_t  f;
  aclre_pkg::aclre_frame_t  g;
  int                       seed = 12;
  int                       err_count = 0;
  int                       comparisons = 0;
  int                       cycles = 0;
  int                       n;

  acl_rule_evaluator #(.N_ENTRY(16)) acl_rule_evaluator_i (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en),
    .I_RD(rd_en), .O_RDATA(rdata), .I_FRAME_VALID(fvalid), .I_FRAME(frame),
    .O_RES_VALID(res_valid), .O_RESULT(result), .O_CNT_EVENT(evt));
  aclre_frame_src aclre_frame_src_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_frame(req), .o_valid(fvalid), .o_frame(frame));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The whole run needs about eleven hundred cycles; far beyond that means a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_res(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_res
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp_reg(rdata, exp);
  endtask : rd_chk
  task automatic put_act(input logic [3:0] e, input logic [12:0] v);
    act_mem[e] = v;
    wr({e, 4'h5}, {19'h0, v});
  endtask : put_act
  function automatic aclre_pkg::aclre_frame_t rnd_frame();
    logic [255:0] r;
    for (int i = 0; i < 8; i++) r = {r[223:0], $random(seed)};
    return aclre_pkg::aclre_frame_t'(r[249:0]);
  endfunction : rnd_frame
  function automatic logic exp_hit(input logic [6:0] c, input logic inv);
    return (c[1:0] != 2'b00) && (c[3:0] != 4'b1110) && (c[5] ^ inv);
  endfunction : exp_hit
  // Case codes keep {polarity, side, option, layer}; the control word puts layer on top.
  function automatic logic [31:0] ctl(input logic [5:0] c);
    return {26'h0, c[1:0], c[3:2], c[4], c[5]};
  endfunction : ctl
  task automatic frame_chk(input aclre_pkg::aclre_frame_t fr, input logic hit,
                           input logic [3:0] idx, input logic [15:0] ev);
    int w;
    @(posedge clk);
    req <= fr;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    w = 0;
    do begin
      @(posedge clk);
      #1;
      w++;
    end while (res_valid !== 1'b1 && w < 8);
    cmp_res({31'h0, res_valid}, 32'h1);
    cmp_res({31'h0, result.hit}, {31'h0, hit});
    if (hit) begin
      cmp_res({28'h0, result.index}, {28'h0, idx});
      cmp_res({19'h0, result.action}, {19'h0, act_mem[idx]});
    end
    cmp_res({16'h0, evt}, {16'h0, ev});
  endtask : frame_chk
  task automatic wait_evt(input int max);
    n = 0;
    while (n < max && evt[0] !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_evt
  // Case code is {side matters, polarity, side, option, layer}; rule 0 feeds action 5.
  task automatic run_case(input logic [6:0] c);
    aclre_pkg::aclre_frame_t fr;
    aclre_pkg::aclre_frame_t gr;
    logic [47:0]             mac;
    fr = rnd_frame();
    fr.is_tcp = (c[3:0] == 4'b0111) || (c[3:0] == 4'b1111);
    fr.is_udp = (c[3:0] == 4'b1011);
    mac = c[4] ? fr.src_mac : fr.dst_mac;
    wr(8'h00, ctl(c[5:0]));
    wr(8'h01, mac[31:0]);
    wr(8'h02, {fr.ether_type, mac[47:32]});
    wr(8'h04, 32'h0000_00FF);
    case (c[3:0])
      4'b0110: wr(8'h03, (c[4] ? fr.src_ip : fr.dst_ip) ^ 32'h0000_00FF);
      4'b1010: begin
        wr(8'h03, fr.src_ip);
        wr(8'h04, fr.dst_ip);
      end
      4'b0011: wr(8'h03, {24'h0, fr.ip_proto});
      4'b1111: wr(8'h03, fr.tcp_seq);
      default: wr(8'h03, {16'h0, c[4] ? fr.src_port : fr.dst_port});
    endcase
    frame_chk(fr, exp_hit(c, 1'b0), 4'h5, 16'h0000);
    gr = ~fr;
    gr.is_tcp = fr.is_tcp;
    gr.is_udp = fr.is_udp;
    frame_chk(gr, exp_hit(c, 1'b1), 4'h5, 16'h0000);
    if (c[6]) begin
      gr = fr;
      if (c[4]) begin
        gr.dst_mac  = ~fr.dst_mac;
        gr.dst_ip   = ~fr.dst_ip;
        gr.dst_port = ~fr.dst_port;
      end else begin
        gr.src_mac  = ~fr.src_mac;
        gr.src_ip   = ~fr.src_ip;
        gr.src_port = ~fr.src_port;
      end
      frame_chk(gr, exp_hit(c, 1'b0), 4'h5, 16'h0000);
    end
  endtask : run_case
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    addr  = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    go    = 1'b0;
    req   = '0;
    cases = '{7'h25, 7'h69, 7'h79, 7'h2D, 7'h05, 7'h76, 7'h2A, 7'h23, 7'h67, 7'h5B,
              7'h2F, 7'h2C, 7'h2E};
    prio  = '{8'hF0, 8'hE3, 8'hA4, 8'h94, 8'hC9, 8'h00};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h05, 32'h0000_0000);
    wr(8'hF5, 32'hFFFF_FFFF);
    rd_chk(8'hF5, 32'h0000_1FFF);
    wr(8'hF6, 32'hFFFF_FFFF);
    rd_chk(8'hF6, 32'h000F_FFFF);
    wr(8'hF6, 32'h0000_0000);
    wr(8'hF8, 32'hFFFF_FFFF);
    rd_chk(8'hF8, 32'h0000_0000);
    wr(8'hF7, 32'hFFFF_FFFF);
    rd_chk(8'hF7, 32'h0000_0000);
    for (int i = 0; i < 16; i++) put_act(4'(i), 13'($random(seed)));
    wr(8'h06, 32'h0005_0001);
    for (int k = 0; k < 26; k++) run_case(cases[k % 13]);
    // Rule 0 counts frames; processing entries 0 and 1 point at it but must never hit.
    f = rnd_frame();
    wr(8'h01, f.dst_mac[31:0]);
    wr(8'h02, {f.ether_type, f.dst_mac[47:32]});
    wr(8'h16, 32'h0002_0001);
    put_act(4'h0, 13'h1003);
    wr(8'h00, ctl(6'h21));
    for (int k = 1; k < 5; k++) frame_chk(f, 1'b0, 4'h0, (k == 3) ? 16'h0001 : 16'h0000);
    put_act(4'h0, 13'h0002);
    frame_chk(f, 1'b0, 4'h0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wait_evt(80);
      cmp_res(32'(n), 32'd80);
      frame_chk(f, 1'b0, 4'h0, 16'h0000);
    end
    wait_evt(400);
    cmp_res({31'h0, n > 98 && n < 203}, 32'h1);
    wr(8'h00, 32'h0000_0000);
    // Rules 1 type, 2 destination address, 3 protocol; entries 3 and 5 share action 4.
    // Entry 6 needs all three rules and points at action 0.
    wr(8'h10, ctl(6'h25));
    wr(8'h12, {f.ether_type, 16'h0000});
    wr(8'h20, ctl(6'h29));
    wr(8'h21, f.dst_mac[31:0]);
    wr(8'h22, {f.ether_type, f.dst_mac[47:32]});
    wr(8'h30, ctl(6'h23));
    wr(8'h33, {24'h0, f.ip_proto});
    wr(8'h26, 32'h0003_0006);
    wr(8'h36, 32'h0004_0008);
    wr(8'h46, 32'h0009_0002);
    wr(8'h56, 32'h0004_0004);
    wr(8'h66, 32'h0000_000E);
    for (int k = 0; k < 6; k++) begin
      g = ~f;
      if (prio[k][6]) g.ether_type = f.ether_type;
      if (prio[k][5]) g.dst_mac = f.dst_mac;
      if (prio[k][4]) g.ip_proto = f.ip_proto;
      frame_chk(g, prio[k][7], prio[k][3:0], 16'h0000);
    end
    // A reset in mid-run must empty the table again.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h66, 32'h0000_0000);
    frame_chk(f, 1'b0, 4'h0, 16'h0000);
    print_verdict();
  end
endmodule : acl_rule_evaluator_tb_top
